// ==== swch_pkg.sv ====
package swch_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_OPTION   = 8'h00;
  localparam logic [7:0] ADDR_TLIMIT   = 8'h04;
  localparam logic [7:0] ADDR_SECCNT   = 8'h08;
  localparam logic [7:0] ADDR_LBA_LO   = 8'h0c;
  localparam logic [7:0] ADDR_LBA_HI   = 8'h10;
  localparam logic [7:0] ADDR_COMMAND  = 8'h14;
  localparam logic [7:0] ADDR_HOBSEL   = 8'h18;
  localparam logic [7:0] ADDR_ERRFLAGS = 8'h1c;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_ERRADDR  = 8'h24;
  localparam logic [7:0] ADDR_TUNIT    = 8'h28;
  localparam logic [7:0] ADDR_STRCFG   = 8'h2c;
  localparam logic [7:0] ADDR_ERRLOG   = 8'h30;

  // Option byte fields
  localparam int OPT_URGENT  = 7;
  localparam int OPT_WCONT   = 6;
  localparam int OPT_FLUSH   = 5;
  localparam int OPT_RESUME  = 4;
  localparam int OPT_SID_HI  = 2;

  // Error flag and status bit positions
  localparam int ERR_TIMEOUT = 0;
  localparam int ERR_ABORT   = 2;
  localparam int ERR_IDNF    = 4;
  localparam int ST_BUSY     = 7;
  localparam int ST_READY    = 6;
  localparam int ST_STRERR   = 5;
  localparam int ST_DRQ      = 3;
  localparam int ST_ERR      = 0;

  // Opcodes
  localparam logic [7:0] OPC_WR_PIO = 8'h3b;
  localparam logic [7:0] OPC_WR_DMA = 8'h3a;

  // Reset values and bus answers
  localparam logic [15:0] TUNIT_RST = 16'h0001;
  localparam logic [1:0]  RESP_OKAY = 2'b00;
  localparam logic [1:0]  RESP_SLV  = 2'b10;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [23:0] MIN_LIMIT_US = 24'd1000;

  typedef enum logic [1:0] {SW_IDLE, SW_XFER, SW_FLUSH, SW_DONE} swch_state_t;

endpackage

// ==== swch_stream_write.sv ====
`timescale 1ns/1ps
module swch_stream_write (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             secReq,
  output logic [47:0]      secLba,
  output logic [2:0]       secStream,
  output logic             secDma,
  output logic             secUrgent,
  input  wire logic        secAck,
  input  wire logic        secErr,
  input  wire logic        secErrIdnf,
  output logic             flushReq,
  input  wire logic        flushDone,
  output logic             cmdDone
);

  // Bus holding state
  logic        awHeld_r;
  logic [7:0]  awAddr_r;
  logic        wHeld_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;

  // Task file
  logic [7:0]  option_r;
  logic [7:0]  tLimit_r;
  logic [15:0] secCnt_r;
  logic [47:0] lba_r;
  logic        hobSel_r;
  logic [15:0] tUnit_r;
  logic [7:0]  errFlags_r;
  logic        strErr_r;
  logic        errBit_r;
  logic [7:0]  errLog_r;
  logic [47:0] errAddr_r;
  logic        errSeen_r;

  // Per-stream memory
  logic [7:0]  dfltLimit_r [8];
  logic        cfgDone_r   [8];
  logic [47:0] lastErr_r   [8];

  // Command engine
  swch_pkg::swch_state_t state_r;
  logic [16:0] remain_r;
  logic [47:0] curLba_r;
  logic [2:0]  sid_r;
  logic        wcont_r;
  logic        flush_r;
  logic        urgent_r;
  logic        dma_r;
  logic        limOn_r;
  logic [23:0] limUs_r;
  logic [23:0] usCnt_r;
  logic [3:0]  preCnt_r;
  logic        done_r;

  logic        wrFire;
  logic        arFire;
  logic        busy;
  logic        cmdStart;
  logic [2:0]  newSid;
  logic [7:0]  limVal;
  logic        limEn;
  logic [23:0] limProd;
  logic        expired;
  logic        lastSec;
  logic [7:0]  rdAddr;
  logic [31:0] rdWord;
  logic        rdHit;
  logic        wrHit;

  // Handshake outputs
  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  assign wrFire = awHeld_r && wHeld_r && !bValid_r;
  assign arFire = s_axi_arvalid && !rValid_r;
  assign rdAddr = s_axi_araddr;
  assign busy   = (state_r != swch_pkg::SW_IDLE);

  // Address and data capture, either order
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Write decode
  always_comb begin
    unique case (awAddr_r)
      swch_pkg::ADDR_OPTION, swch_pkg::ADDR_TLIMIT, swch_pkg::ADDR_SECCNT,
      swch_pkg::ADDR_LBA_LO, swch_pkg::ADDR_LBA_HI, swch_pkg::ADDR_COMMAND,
      swch_pkg::ADDR_HOBSEL, swch_pkg::ADDR_TUNIT, swch_pkg::ADDR_STRCFG:
        wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bValid_r <= 1'b0;
      bResp_r  <= swch_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bValid_r <= 1'b1;
      bResp_r  <= wrHit ? swch_pkg::RESP_OKAY : swch_pkg::RESP_SLV;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // Task file writes, ignored while a command runs except HOBSEL
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      option_r <= 8'h00;
      tLimit_r <= 8'h00;
      secCnt_r <= 16'h0000;
      lba_r    <= 48'h0;
      hobSel_r <= 1'b0;
      tUnit_r  <= swch_pkg::TUNIT_RST;
    end else if (wrFire && !busy && wStrb_r[0]) begin
      unique case (awAddr_r)
        swch_pkg::ADDR_OPTION: option_r <= wData_r[7:0];
        swch_pkg::ADDR_TLIMIT: tLimit_r <= wData_r[7:0];
        swch_pkg::ADDR_SECCNT: secCnt_r <= wData_r[15:0];
        swch_pkg::ADDR_LBA_LO: lba_r[23:0] <= wData_r[23:0];
        swch_pkg::ADDR_LBA_HI: lba_r[47:24] <= wData_r[23:0];
        swch_pkg::ADDR_HOBSEL: hobSel_r <= wData_r[0];
        swch_pkg::ADDR_TUNIT:  tUnit_r <= wData_r[15:0];
        default: ;
      endcase
    end else if (wrFire && wStrb_r[0] && awAddr_r == swch_pkg::ADDR_HOBSEL) begin
      hobSel_r <= wData_r[0];
    end
  end

  // Stream defaults: id in bits 2:0, default limit in bits 15:8
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        dfltLimit_r[i] <= 8'h00;
        cfgDone_r[i]   <= 1'b0;
      end
    end else if (wrFire && !busy && awAddr_r == swch_pkg::ADDR_STRCFG) begin
      dfltLimit_r[wData_r[2:0]] <= wData_r[15:8];
      cfgDone_r[wData_r[2:0]]   <= 1'b1;
    end
  end

  // Command start and completion limit selection
  assign cmdStart = wrFire && !busy && wStrb_r[0] && awAddr_r == swch_pkg::ADDR_COMMAND
                    && (wData_r[7:0] == swch_pkg::OPC_WR_PIO
                        || wData_r[7:0] == swch_pkg::OPC_WR_DMA);
  assign newSid  = option_r[swch_pkg::OPT_SID_HI:0];
  assign limVal  = (tLimit_r != 8'h00) ? tLimit_r : dfltLimit_r[newSid];
  assign limEn   = (limVal != 8'h00) && (tLimit_r != 8'h00 || cfgDone_r[newSid]);
  assign limProd = {16'h0000, limVal} * {8'h00, tUnit_r};
  assign expired = limOn_r && (usCnt_r >= limUs_r);
  assign lastSec = (remain_r == 17'd1);

  // Microsecond timer from command write to completion
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      preCnt_r <= 4'h0;
      usCnt_r  <= 24'h0;
    end else if (cmdStart || !busy) begin
      preCnt_r <= 4'h0;
      usCnt_r  <= 24'h0;
    end else if (preCnt_r == 4'(swch_pkg::US_CYC - 1)) begin
      preCnt_r <= 4'h0;
      usCnt_r  <= usCnt_r + 24'd1;
    end else begin
      preCnt_r <= preCnt_r + 4'h1;
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r  <= swch_pkg::SW_IDLE;
      remain_r <= 17'h0;
      curLba_r <= 48'h0;
      sid_r    <= 3'h0;
      wcont_r  <= 1'b0;
      flush_r  <= 1'b0;
      urgent_r <= 1'b0;
      dma_r    <= 1'b0;
      limOn_r  <= 1'b0;
      limUs_r  <= 24'h0;
      done_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        swch_pkg::SW_IDLE: begin
          if (cmdStart) begin
            state_r  <= swch_pkg::SW_XFER;
            remain_r <= (secCnt_r == 16'h0000) ? 17'h10000 : {1'b0, secCnt_r};
            curLba_r <= option_r[swch_pkg::OPT_RESUME] ? lastErr_r[newSid] : lba_r;
            sid_r    <= newSid;
            wcont_r  <= option_r[swch_pkg::OPT_WCONT];
            flush_r  <= option_r[swch_pkg::OPT_FLUSH];
            urgent_r <= option_r[swch_pkg::OPT_URGENT];
            dma_r    <= (wData_r[7:0] == swch_pkg::OPC_WR_DMA);
            limOn_r  <= limEn;
            limUs_r  <= (limProd < swch_pkg::MIN_LIMIT_US) ? swch_pkg::MIN_LIMIT_US : limProd;
          end
        end
        swch_pkg::SW_XFER: begin
          if (expired) begin
            state_r <= swch_pkg::SW_DONE;
          end else if (secAck) begin
            curLba_r <= curLba_r + 48'd1;
            remain_r <= remain_r - 17'd1;
            if (secErr && !wcont_r) begin
              state_r <= swch_pkg::SW_DONE;
            end else if (lastSec) begin
              state_r <= flush_r ? swch_pkg::SW_FLUSH : swch_pkg::SW_DONE;
            end
          end
        end
        swch_pkg::SW_FLUSH: begin
          if (expired || flushDone) begin
            state_r <= swch_pkg::SW_DONE;
          end
        end
        swch_pkg::SW_DONE: begin
          state_r <= swch_pkg::SW_IDLE;
          done_r  <= 1'b1;
        end
      endcase
    end
  end

  // Ending status, error flags, failing address and stream error memory
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      errFlags_r <= 8'h00;
      strErr_r   <= 1'b0;
      errBit_r   <= 1'b0;
      errLog_r   <= 8'h00;
      errAddr_r  <= 48'h0;
      errSeen_r  <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        lastErr_r[i] <= 48'h0;
      end
    end else if (cmdStart) begin
      errFlags_r <= 8'h00;
      strErr_r   <= 1'b0;
      errBit_r   <= 1'b0;
      errSeen_r  <= 1'b0;
    end else if (busy && expired && state_r != swch_pkg::SW_DONE) begin
      errFlags_r[swch_pkg::ERR_TIMEOUT] <= 1'b1;
      errLog_r[swch_pkg::ERR_TIMEOUT]   <= 1'b1;
      strErr_r <= wcont_r;
      errBit_r <= !wcont_r;
      if (!wcont_r) begin
        errFlags_r[swch_pkg::ERR_ABORT] <= 1'b1;
      end
    end else if (state_r == swch_pkg::SW_XFER && secAck && secErr) begin
      lastErr_r[sid_r] <= curLba_r;
      errLog_r[secErrIdnf ? swch_pkg::ERR_IDNF : swch_pkg::ERR_ABORT] <= 1'b1;
      errFlags_r[secErrIdnf ? swch_pkg::ERR_IDNF : swch_pkg::ERR_ABORT] <= 1'b1;
      if (!errSeen_r) begin
        errAddr_r <= curLba_r;
        errSeen_r <= 1'b1;
      end
      strErr_r <= wcont_r;
      errBit_r <= !wcont_r;
    end
  end

  // Register read mux
  always_comb begin
    rdWord = 32'h0000_0000;
    rdHit  = 1'b1;
    unique case (rdAddr)
      swch_pkg::ADDR_TLIMIT: rdWord[7:0]  = tLimit_r;
      swch_pkg::ADDR_SECCNT: rdWord[15:0] = secCnt_r;
      swch_pkg::ADDR_LBA_LO: rdWord[23:0] = lba_r[23:0];
      swch_pkg::ADDR_LBA_HI: rdWord[23:0] = lba_r[47:24];
      swch_pkg::ADDR_HOBSEL: rdWord[0]    = hobSel_r;
      swch_pkg::ADDR_ERRFLAGS: rdWord[7:0] = errFlags_r;
      swch_pkg::ADDR_STATUS: begin
        rdWord[swch_pkg::ST_BUSY]   = busy;
        rdWord[swch_pkg::ST_READY]  = 1'b1;
        rdWord[swch_pkg::ST_STRERR] = strErr_r;
        rdWord[swch_pkg::ST_DRQ]    = secReq && !dma_r;
        rdWord[swch_pkg::ST_ERR]    = errBit_r;
      end
      swch_pkg::ADDR_ERRADDR:
        rdWord[23:0] = hobSel_r ? errAddr_r[47:24] : errAddr_r[23:0];
      swch_pkg::ADDR_TUNIT:  rdWord[15:0] = tUnit_r;
      swch_pkg::ADDR_ERRLOG: rdWord[7:0]  = errLog_r;
      swch_pkg::ADDR_OPTION, swch_pkg::ADDR_COMMAND, swch_pkg::ADDR_STRCFG: ;
      default: rdHit = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= swch_pkg::RESP_OKAY;
    end else if (arFire) begin
      rValid_r <= 1'b1;
      rData_r  <= rdWord;
      rResp_r  <= rdHit ? swch_pkg::RESP_OKAY : swch_pkg::RESP_SLV;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // Media side: one sector requested at a time
  assign secReq    = (state_r == swch_pkg::SW_XFER) && !expired;
  assign secLba    = curLba_r;
  assign secStream = sid_r;
  assign secDma    = dma_r;
  assign secUrgent = urgent_r && busy;
  assign flushReq  = (state_r == swch_pkg::SW_FLUSH);
  assign cmdDone   = done_r;

endmodule

// ==== swch_checker.sv ====
`timescale 1ns/1ps
module swch_checker (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        secReq,
  input wire logic [47:0] secLba,
  input wire logic [2:0]  secStream,
  input wire logic        secUrgent,
  input wire logic        secAck,
  input wire logic        flushReq,
  input wire logic        flushDone,
  input wire logic        cmdDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Completion only once sectors and flush are over
  property p_done_idle; cmdDone |-> !secReq && !flushReq; endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
  // Sectors are asked for one after another
  property p_lba_step;
    secReq && secAck |=> !secReq || secLba == $past(secLba) + 48'h1;
  endproperty
  a_lba_step: assert property (p_lba_step) else $error("sector address skipped");
  // Flush follows the transfer, completion follows the flush
  property p_req_flush; secReq |-> !flushReq; endproperty
  a_req_flush: assert property (p_req_flush) else $error("flush during transfer");
  property p_flush_end; flushReq && flushDone |-> ##[1:3] cmdDone; endproperty
  a_flush_end: assert property (p_flush_end) else $error("no completion after flush");
  // Command settings stay put during the transfer
  property p_sid_hold; secReq && $past(secReq) |-> $stable(secStream); endproperty
  a_sid_hold: assert property (p_sid_hold) else $error("stream changed");
  property p_urg_hold; secReq ##1 secReq |-> $stable(secUrgent); endproperty
  a_urg_hold: assert property (p_urg_hold) else $error("urgent changed");
  // Register bus answers
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read not answered");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
endmodule

bind swch_stream_write swch_checker chk (.sys_clk, .sys_rst, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .secReq, .secLba, .secStream, .secUrgent,
  .secAck, .flushReq, .flushDone, .cmdDone);

// ==== swch_media_model.sv ====
`timescale 1ns/1ps
module swch_media_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        secReq,
  input  wire logic [47:0] secLba,
  input  wire logic        flushReq,
  input  wire logic [15:0] ackDly,
  input  wire logic        errOn,
  input  wire logic        errIdnf,
  input  wire logic [47:0] errLba,
  output logic             secAck,
  output logic             secErr,
  output logic             secErrIdnf,
  output logic             flushDone
);
  logic [15:0] waitCnt_r;
  logic [1:0]  flushCnt_r;

  // Sector done once its wait has run out; on an ack, error only on the chosen sector
  assign secAck = secReq && (waitCnt_r >= ackDly);
  assign secErr = secAck ? errOn && (secLba == errLba) : !secLba[0];
  assign secErrIdnf = secErr && errIdnf;
  assign flushDone = flushReq && (flushCnt_r == 2'h2);

  // Wait per sector
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !secReq || secAck) begin
      waitCnt_r <= 16'h0000;
    end else begin
      waitCnt_r <= waitCnt_r + 16'h0001;
    end
  end

  // Flush time
  always_ff @(posedge sys_clk) begin
    flushCnt_r <= (sys_rst || !flushReq) ? 2'h0 : flushCnt_r + 2'h1;
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`define SWCH_CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  typedef struct {
    logic [7:0] opt; logic [15:0] cnt; logic dma; int errAt; logic idnf;
    logic [7:0] st; logic [7:0] ef; int acks;
  } swch_row_t;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        secReq, secDma, secUrgent, secAck, secErr, secErrIdnf, flushReq, flushDone;
  logic        cmdDone, seenDma, seenUrg, errOn = 1'b0, errIdnf = 1'b0;
  logic [47:0] secLba, firstLba, expLba, errLba = 48'h0, lastErr [8];
  logic [2:0]  secStream, seenSid;
  logic [15:0] ackDly = 16'h0002;
  int          bad_count = 0, samples_checked = 0, acks = 0, flushCyc = 0, cyc = 0;
  swch_row_t   rows [8] = '{
    '{8'h01, 16'h0002, 1'b0, 0, 1'b0, 8'h40, 8'h00, 2},
    '{8'h82, 16'h0003, 1'b1, 0, 1'b0, 8'h40, 8'h00, 3},
    '{8'h43, 16'h0004, 1'b0, 2, 1'b1, 8'h60, 8'h00, 4},
    '{8'h24, 16'h0002, 1'b1, 0, 1'b0, 8'h40, 8'h00, 2},
    '{8'h06, 16'h0005, 1'b0, 3, 1'b0, 8'h41, 8'h04, 3},
    '{8'h16, 16'h0001, 1'b0, 0, 1'b0, 8'h40, 8'h00, 1},
    '{8'h07, 16'h0002, 1'b0, 1, 1'b1, 8'h41, 8'h10, 1},
    '{8'h00, 16'h0000, 1'b0, 0, 1'b0, 8'h40, 8'h00, 65536}};

  always #(swch_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  swch_stream_write dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .secReq, .secLba, .secStream, .secDma, .secUrgent, .secAck,
    .secErr, .secErrIdnf, .flushReq, .flushDone, .cmdDone);
  swch_media_model media (.sys_clk, .sys_rst, .secReq, .secLba, .flushReq, .ackDly, .errOn,
    .errIdnf, .errLba, .secAck, .secErr, .secErrIdnf, .flushDone);

  // Watch the sector link of each command
  always @(posedge sys_clk) begin
    if (secReq && secAck && acks == 0) begin
      {firstLba, seenSid, seenDma, seenUrg} <= {secLba, secStream, secDma, secUrgent};
    end
    if (secReq && secAck) acks <= acks + 1;
    if (flushReq) flushCyc <= flushCyc + 1;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) bad_count++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    {rsp, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
    if (n >= 50) bad_count++;
  endtask

  task automatic run(input logic [7:0] opt, input logic [15:0] cnt, input logic dma,
                     input logic [7:0] tl);
    acks = 0;
    flushCyc = 0;
    wr(swch_pkg::ADDR_OPTION, {24'h0, opt});
    wr(swch_pkg::ADDR_TLIMIT, {24'h0, tl});
    wr(swch_pkg::ADDR_SECCNT, {16'h0, cnt});
    wr(swch_pkg::ADDR_LBA_LO, 32'h00abcdef);
    wr(swch_pkg::ADDR_LBA_HI, 32'h00123456);
    wr(swch_pkg::ADDR_COMMAND, {24'h0, dma ? swch_pkg::OPC_WR_DMA : swch_pkg::OPC_WR_PIO});
    cyc = 0;
    while (!cmdDone && cyc < 70000) begin
      @(posedge sys_clk);
      cyc++;
    end
    if (cyc >= 70000) bad_count++;
  endtask

  task automatic tmo(input logic [7:0] opt, input logic [7:0] tl, input logic [15:0] unit,
                     input int n, input logic [7:0] st, input logic [7:0] ef);
    wr(swch_pkg::ADDR_TUNIT, {16'h0, unit});
    run(opt, 16'h0001, 1'b0, tl);
    `SWCH_CHK(cyc >= n - 3 && cyc <= n + 5, 1'b1)
    rd(swch_pkg::ADDR_STATUS);
    `SWCH_CHK(d[7:0], st)
    rd(swch_pkg::ADDR_ERRFLAGS);
    `SWCH_CHK(d[7:0], ef)
    $display("timeout case done after %0d cycles", cyc);
  endtask

  task automatic give_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (120000) @(posedge sys_clk);
    bad_count++;
    give_verdict();
  end

  // Reset values, row loop, then timeouts
  initial begin
    swch_row_t r;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(swch_pkg::ADDR_STATUS);
    `SWCH_CHK(d[7:0], 8'h40)
    rd(swch_pkg::ADDR_TUNIT);
    `SWCH_CHK(d[15:0], swch_pkg::TUNIT_RST)
    rd(8'h3c);
    `SWCH_CHK({rsp, d}, {swch_pkg::RESP_SLV, 32'h0})
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      errLba <= 48'h123456abcdef + 48'(r.errAt) - 48'h1;
      {errOn, errIdnf} <= {r.errAt != 0, r.idnf};
      ackDly <= (r.cnt == 16'h0000) ? 16'h0000 : 16'h0002;
      run(r.opt, r.cnt, r.dma, 8'h00);
      expLba = r.opt[4] ? lastErr[r.opt[2:0]] : 48'h123456abcdef;
      if (r.errAt != 0) lastErr[r.opt[2:0]] = errLba;
      rd(swch_pkg::ADDR_STATUS);
      `SWCH_CHK(d[7:0], r.st)
      rd(swch_pkg::ADDR_ERRFLAGS);
      `SWCH_CHK(d[7:0] & (r.opt[6] ? 8'h01 : 8'hff), r.ef)
      `SWCH_CHK(acks, r.acks)
      `SWCH_CHK(seenSid, r.opt[2:0])
      `SWCH_CHK({seenDma, seenUrg}, {r.dma, r.opt[7]})
      `SWCH_CHK(firstLba, expLba)
      `SWCH_CHK(flushCyc != 0, r.opt[5])
      if (r.errAt != 0 && !r.opt[6]) begin
        wr(swch_pkg::ADDR_HOBSEL, 32'h0);
        rd(swch_pkg::ADDR_ERRADDR);
        `SWCH_CHK(d[23:0], errLba[23:0])
        wr(swch_pkg::ADDR_HOBSEL, 32'h1);
        rd(swch_pkg::ADDR_ERRADDR);
        `SWCH_CHK(d[23:0], errLba[47:24])
      end
      $display("row %0d done", i);
    end
    rd(swch_pkg::ADDR_ERRLOG);
    `SWCH_CHK(d[4], 1'b1)
    ackDly <= 16'hffff;
    errOn <= 1'b0;
    tmo(8'h41, 8'h01, 16'h0001, 10000, 8'h60, 8'h01);
    tmo(8'h02, 8'h03, 16'h015e, 10500, 8'h41, 8'h05);
    wr(swch_pkg::ADDR_STRCFG, 32'h00000305);
    `SWCH_CHK(rsp, swch_pkg::RESP_OKAY)
    tmo(8'h45, 8'h00, 16'h015e, 10500, 8'h60, 8'h01);
    // Refused writes: masked strobe, unknown opcode, unmapped address
    s_axi_wstrb <= 4'he;
    wr(swch_pkg::ADDR_TUNIT, 32'h0000_0077);
    s_axi_wstrb <= 4'hf;
    rd(swch_pkg::ADDR_TUNIT);
    `SWCH_CHK(d[15:0], 16'h015e)
    wr(swch_pkg::ADDR_COMMAND, 32'h0000_00a5);
    rd(swch_pkg::ADDR_STATUS);
    `SWCH_CHK(d[7:0], 8'h60)
    wr(8'h3c, 32'h0000_0001);
    `SWCH_CHK(rsp, swch_pkg::RESP_SLV)
    $display("refused writes done");
    give_verdict();
  end
endmodule
